// ===== nmi_irq_pkg.sv
package nmi_irq_pkg;

   localparam int NUM_INPUTS = 16;
   localparam int PRIO_W     = 4;
   localparam int ADDR_W     = 8;
   localparam int DATA_W     = 8;

   // register offsets on the plain register port
   localparam logic [7:0] OFS_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_ENABLE_STB   = 8'h01;
   localparam logic [7:0] OFS_RETURN       = 8'h02;
   localparam logic [7:0] OFS_PENDING_HIGH = 8'h03;
   localparam logic [7:0] OFS_PRIO_BASE    = 8'h04;
   localparam logic [7:0] OFS_PORT_MODE    = 8'h0c;
   localparam logic [7:0] OFS_PORT_PRESC   = 8'h0d;

   // control register bit positions
   localparam int CTL_CLEAR_BIT = 0;
   localparam int CTL_A1_BIT    = 1;
   localparam int CTL_GEN_BIT   = 2;
   localparam int CTL_DAS_BIT   = 3;
   localparam int CTL_RST_BIT   = 4;

   localparam logic       GEN_RESET       = 1'b1;
   localparam logic       DAS_RESET       = 1'b1;
   localparam logic [7:0] PRIO_RESET      = 8'h00;
   localparam logic [7:0] PORT_MODE_RESET = 8'h00;
   localparam logic [1:0] PRESC_RESET     = 2'h0;

   // vector locations: input 0 at ffe2, each next two bytes lower
   localparam logic [23:0] VEC_BASE     = 24'h00ffe2;
   localparam logic [23:0] VEC_STEP     = 24'h000002;
   // cpu vector low address for both cpu modes
   localparam logic [23:0] VEC_FETCH_EMU    = 24'h00fffa;
   localparam logic [23:0] VEC_FETCH_NATIVE = 24'h00ffea;

   // trigger encodings of a port mode field
   localparam logic [1:0] TRIG_RISE = 2'h0;
   localparam logic [1:0] TRIG_FALL = 2'h1;
   localparam logic [1:0] TRIG_BOTH = 2'h2;
   localparam logic [1:0] TRIG_OFF  = 2'h3;

   localparam int PRESC0_DIV = 4;
   localparam int PRESC1_DIV = 32;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } reg_req_t;

   typedef struct packed {
      logic [23:0] addr;
      logic        vec_fetch;
   } cpu_bus_t;

endpackage

// ===== nmi_irq_ctrl.sv
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
module nmi_irq_ctrl #(
   parameter int PRESC0_DIV = nmi_irq_pkg::PRESC0_DIV,
   parameter int PRESC1_DIV = nmi_irq_pkg::PRESC1_DIV
) (
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst_n,
   input  wire logic                  i_clk_en,
   input  wire nmi_irq_pkg::reg_req_t i_reg,
   output logic [7:0]                 o_reg_rdata,
   input  wire nmi_irq_pkg::cpu_bus_t i_cpu,
   input  wire logic                  i_instr_done,
   output logic                       o_nmi_n,
   output logic                       o_rdy,
   output logic                       o_vec_valid,
   output logic [23:0]                o_vec_addr,
   input  wire logic [15:0]           i_direct_src,
   input  wire logic [3:0]            i_pin_irq,
   input  wire logic [31:0]           i_periph_src,
   input  wire logic [7:0]            i_opt_byte0,
   input  wire logic [7:0]            i_opt_byte1,
   input  wire logic [1:0]            i_opt_byte2
);

   // the divide counters are five bits wide
   if (PRESC0_DIV < 2 || PRESC0_DIV % 2 != 0 || PRESC0_DIV > 32 ||
       PRESC1_DIV < 2 || PRESC1_DIV % 2 != 0 || PRESC1_DIV > 32) begin
      $error("prescaler ratios must be even, from two to thirty-two");
   end

   localparam int STK_DEPTH = 15;

   typedef enum {
      ST_IDLE,
      ST_EVAL,
      ST_WAIT_FETCH,
      ST_STALL
   } fsm_t;

   typedef struct packed {
      fsm_t                 st;
      logic [7:0]           rdata;
      logic                 gen;
      logic                 das;
      logic                 one_armed;
      logic [1:0]           en_pend;
      logic [15:0]          pend_n;
      logic [63:0]          prio;
      logic [7:0]           pmode;
      logic [1:0]           presc_on;
      logic [4:0]           div0;
      logic [4:0]           div1;
      logic [3:0]           pin_s1;
      logic [3:0]           pin_s2;
      logic [3:0]           pin_prev;
      logic [3:0]           pre_prev;
      logic [15:0]          src_prev;
      logic [3:0]           lat_prio;
      logic [3:0]           lat_idx;
      logic [59:0]          stk;
      logic [3:0]           sp;
      logic                 nmi_n;
      logic                 rdy;
      logic                 vvalid;
      logic [23:0]          vaddr;
   } state_t;

   state_t q;
   state_t d;

   ////////////////////////////////////////////////////////////////////////
   function automatic logic edge_hit(input logic [1:0] mode, input logic prv, input logic cur);
      unique case (mode)
         nmi_irq_pkg::TRIG_RISE: edge_hit = !prv && cur;
         nmi_irq_pkg::TRIG_FALL: edge_hit = prv && !cur;
         nmi_irq_pkg::TRIG_BOTH: edge_hit = prv != cur;
         default:                edge_hit = 1'b0;
      endcase
   endfunction

   function automatic logic sel4(input logic [1:0] s, input logic [3:0] v);
      sel4 = v[s];
   endfunction

   function automatic logic [3:0] stack_top(input logic [59:0] stk, input logic [3:0] sp);
      stack_top = (sp == 4'h0) ? 4'h0 : stk[4*(sp-4'h1) +: 4];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   logic [3:0]  pin_edge;
   logic [3:0]  pre_sig;
   logic [15:0] src;
   logic [3:0]  best_prio;
   logic [3:0]  best_idx;
   logic        wr_ctl;
   logic        rst_wr;
   logic        clr_wr;
   logic        a1_wr;
   logic        ret_wr;
   logic        fetch_seen;

   always_comb begin
      // prescaled pins toggle half way through ratio for a 50% output
      pre_sig[0] = q.presc_on[0] ? q.div0 >= 5'(PRESC0_DIV / 2) : q.pin_s2[0];
      pre_sig[1] = q.presc_on[1] ? q.div1 >= 5'(PRESC1_DIV / 2) : q.pin_s2[1];
      pre_sig[2] = q.pin_s2[2];
      pre_sig[3] = q.pin_s2[3];
      for (int p = 0; p < 4; p++) begin
         pin_edge[p] = edge_hit(q.pmode[2*p +: 2], q.pre_prev[p], pre_sig[p]);
      end
      // periph source bundle: four candidates per selector, pins folded in below
      src = i_direct_src;
      src[3]  = pin_edge[0];
      src[4]  = pin_edge[1];
      src[5]  = sel4(i_opt_byte0[1:0], i_periph_src[3:0]);
      src[6]  = sel4(i_opt_byte0[3:2], i_periph_src[7:4]);
      src[7]  = sel4(i_opt_byte0[5:4], {i_periph_src[10:8], pin_edge[3]});
      src[13] = sel4(i_opt_byte0[7:6], {pin_edge[3], i_periph_src[14:12]});
      src[14] = sel4(i_opt_byte1[1:0], i_periph_src[19:16]);
      src[15] = sel4(i_opt_byte1[3:2], {pin_edge[2], i_periph_src[22:20]});
      src[0]  = sel4(i_opt_byte1[5:4], i_periph_src[27:24]);
      src[1]  = sel4(i_opt_byte1[7:6], {i_periph_src[31:30], pin_edge[2], i_periph_src[28]});
      src[10] = sel4(i_opt_byte2, {i_periph_src[15], i_periph_src[11], i_periph_src[23], i_periph_src[29]});
      // later index wins ties because of >=
      best_prio = 4'h0;
      best_idx  = 4'h0;
      for (int n = 0; n < 16; n++) begin
         if (!q.pend_n[n] && q.prio[4*n +: 4] != 4'h0 && q.prio[4*n +: 4] >= best_prio) begin
            best_prio = q.prio[4*n +: 4];
            best_idx  = 4'(n);
         end
      end
   end

   assign wr_ctl     = i_reg.wr && i_reg.addr == nmi_irq_pkg::OFS_CONTROL;
   assign rst_wr     = wr_ctl && !i_reg.wdata[nmi_irq_pkg::CTL_RST_BIT];
   assign clr_wr     = wr_ctl && !i_reg.wdata[nmi_irq_pkg::CTL_CLEAR_BIT];
   assign a1_wr      = wr_ctl && !i_reg.wdata[nmi_irq_pkg::CTL_A1_BIT];
   assign ret_wr     = i_reg.wr && i_reg.addr == nmi_irq_pkg::OFS_RETURN;
   assign fetch_seen = i_cpu.vec_fetch && (i_cpu.addr == nmi_irq_pkg::VEC_FETCH_EMU ||
                                            i_cpu.addr == nmi_irq_pkg::VEC_FETCH_NATIVE);

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      d = q;
      d.pin_s1   = i_pin_irq;
      d.pin_s2   = q.pin_s1;
      d.pin_prev = q.pin_s2;
      d.pre_prev = pre_sig;
      d.src_prev = src;
      d.vvalid   = 1'b0;
      if (q.presc_on[0] && q.pin_s2[0] && !q.pin_prev[0]) begin
         d.div0 = (q.div0 == 5'(PRESC0_DIV - 1)) ? 5'h0 : q.div0 + 5'h1;
      end
      if (q.presc_on[1] && q.pin_s2[1] && !q.pin_prev[1]) begin
         d.div1 = (q.div1 == 5'(PRESC1_DIV - 1)) ? 5'h0 : q.div1 + 5'h1;
      end
      // requests record regardless of priority; set beats clear
      for (int n = 0; n < 16; n++) begin
         if (clr_wr) begin
            d.pend_n[n] = 1'b1;
         end
         if (src[n] && !q.src_prev[n]) begin
            d.pend_n[n] = 1'b0;
         end
      end
      if (q.en_pend != 2'h0 && i_instr_done) begin
         d.en_pend = q.en_pend - 2'h1;
         if (q.en_pend == 2'h1) begin
            d.gen = 1'b1;
         end
      end
      if (i_reg.wr) begin
         unique case (i_reg.addr)
            nmi_irq_pkg::OFS_CONTROL: begin
               d.gen = i_reg.wdata[nmi_irq_pkg::CTL_GEN_BIT];
               d.das = i_reg.wdata[nmi_irq_pkg::CTL_DAS_BIT];
               if (a1_wr) begin
                  d.one_armed = 1'b1;
                  d.gen       = 1'b1;
               end
            end
            // count this write's instruction end, then the following one
            nmi_irq_pkg::OFS_ENABLE_STB: d.en_pend = 2'h2;
            nmi_irq_pkg::OFS_PORT_MODE:  d.pmode = i_reg.wdata;
            nmi_irq_pkg::OFS_PORT_PRESC: d.presc_on = i_reg.wdata[1:0];
            default: begin
               for (int k = 0; k < 8; k++) begin
                  if (i_reg.addr == nmi_irq_pkg::OFS_PRIO_BASE + 8'(k)) begin
                     d.prio[8*k +: 8] = i_reg.wdata;
                  end
               end
            end
         endcase
      end
      if (ret_wr && q.sp != 4'h0) begin
         d.sp = q.sp - 4'h1;
      end
      unique case (q.st)
         ST_IDLE: begin
            // evaluation latch: strictly higher than stack top
            if (q.gen && best_prio > stack_top(q.stk, q.sp) && !ret_wr) begin
               d.lat_prio = best_prio;
               d.lat_idx  = best_idx;
               d.st       = ST_EVAL;
            end
         end
         ST_EVAL: begin
            // priority changes in this cycle cannot cancel the request
            d.nmi_n = 1'b0;
            // a return write in this cycle pops first, then the push lands
            if (d.sp != 4'(STK_DEPTH)) begin
               d.stk[4*d.sp +: 4] = q.lat_prio;
               d.sp = d.sp + 4'h1;
            end
            if (!q.das) begin
               d.gen       = 1'b0;
               d.one_armed = 1'b0;
            end
            d.st = ST_WAIT_FETCH;
         end
         ST_WAIT_FETCH: begin
            if (fetch_seen) begin
               d.rdy = 1'b0;
               d.st  = ST_STALL;
            end
         end
         ST_STALL: begin
            d.vaddr  = nmi_irq_pkg::VEC_BASE - 24'(q.lat_idx) * nmi_irq_pkg::VEC_STEP;
            d.vvalid = 1'b1;
            d.rdy    = 1'b1;
            d.nmi_n  = 1'b1;
            // a fresh request in the give cycle stays pending
            if (!(src[q.lat_idx] && !q.src_prev[q.lat_idx])) begin
               d.pend_n[q.lat_idx] = 1'b1;
            end
            d.st     = ST_IDLE;
         end
      endcase
      d.rdata = 8'h00;
      if (i_reg.rd) begin
         if (i_reg.addr == nmi_irq_pkg::OFS_CONTROL) begin
            d.rdata[nmi_irq_pkg::CTL_GEN_BIT] = q.gen;
            d.rdata[nmi_irq_pkg::CTL_DAS_BIT] = q.das;
         end else if (i_reg.addr == nmi_irq_pkg::OFS_RETURN) begin
            d.rdata = q.pend_n[7:0];
         end else if (i_reg.addr == nmi_irq_pkg::OFS_PENDING_HIGH) begin
            d.rdata = q.pend_n[15:8];
         end else begin
            for (int k = 0; k < 8; k++) begin
               if (i_reg.addr == nmi_irq_pkg::OFS_PRIO_BASE + 8'(k)) begin
                  d.rdata = q.prio[8*k +: 8];
               end
            end
         end
      end
      // momentary soft reset beats all else except read data, pin and edge history, the request latch, and the vector pulse and address from ST_STALL
      if (rst_wr) begin
         d.st       = ST_IDLE;
         d.gen      = nmi_irq_pkg::GEN_RESET;
         d.das      = nmi_irq_pkg::DAS_RESET;
         d.one_armed = 1'b0;
         d.en_pend  = 2'h0;
         d.pend_n   = '1;
         d.prio     = '0;
         d.pmode    = nmi_irq_pkg::PORT_MODE_RESET;
         d.presc_on = nmi_irq_pkg::PRESC_RESET;
         d.div0     = 5'h0;
         d.div1     = 5'h0;
         d.stk      = '0;
         d.sp       = 4'h0;
         d.nmi_n    = 1'b1;
         d.rdy      = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         q          <= '0;
         q.st       <= ST_IDLE;
         q.gen      <= nmi_irq_pkg::GEN_RESET;
         q.das      <= nmi_irq_pkg::DAS_RESET;
         q.pend_n   <= '1;
         q.prio     <= '0;
         q.pmode    <= nmi_irq_pkg::PORT_MODE_RESET;
         q.presc_on <= nmi_irq_pkg::PRESC_RESET;
         q.nmi_n    <= 1'b1;
         q.rdy      <= 1'b1;
      end else if (i_clk_en) begin
         q <= d;
      end
   end

   assign o_reg_rdata = q.rdata;
   assign o_nmi_n     = q.nmi_n;
   assign o_rdy       = q.rdy;
   assign o_vec_valid = q.vvalid;
   assign o_vec_addr  = q.vaddr;

endmodule

// ===== nmi_irq_ctrl_properties.sv
`timescale 1ns/1ps
module nmi_irq_ctrl_properties (
   input wire logic                  i_ref_clk,
   input wire logic                  i_rst_n,
   input wire nmi_irq_pkg::reg_req_t i_reg,
   input wire logic [7:0]            o_reg_rdata,
   input wire nmi_irq_pkg::cpu_bus_t i_cpu,
   input wire logic                  o_nmi_n,
   input wire logic                  o_rdy,
   input wire logic                  o_vec_valid,
   input wire logic [23:0]           o_vec_addr
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   ////////////////////////////////////////////////////////////
   property p_rdata_idle;
      !$past(i_reg.rd) |-> o_reg_rdata == 8'h00;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle)
      else $error("read data not zero outside read cycle");
   property p_rdata_ctl;
      $past(i_reg.rd && i_reg.addr == nmi_irq_pkg::OFS_CONTROL) |-> (o_reg_rdata & 8'hf3) == 8'h00;
   endproperty
   a_rdata_ctl: assert property (p_rdata_ctl)
      else $error("control read shows unused bits");
   property p_vec_range;
      o_vec_valid |-> o_vec_addr >= 24'h00ffc4 && o_vec_addr <= 24'h00ffe2 && !o_vec_addr[0];
   endproperty
   a_vec_range: assert property (p_vec_range)
      else $error("vector outside table");
   property p_vec_nmi;
      o_vec_valid |-> o_nmi_n && o_rdy;
   endproperty
   a_vec_nmi: assert property (p_vec_nmi)
      else $error("vector given while request or stall held");
   property p_vec_pulse;
      o_vec_valid |=> !o_vec_valid;
   endproperty
   a_vec_pulse: assert property (p_vec_pulse)
      else $error("vector valid longer than one cycle");
   property p_fetch_stall;
      $rose(i_cpu.vec_fetch) && !o_nmi_n |=> !o_rdy ##1 (o_rdy && o_vec_valid);
   endproperty
   a_fetch_stall: assert property (p_fetch_stall)
      else $error("vector fetch not stalled and answered");
   property p_stall_nmi;
      !o_rdy |-> !o_nmi_n ##1 o_rdy;
   endproperty
   a_stall_nmi: assert property (p_stall_nmi)
      else $error("stall without request or too long");
   property p_nmi_release;
      !o_nmi_n ##1 o_nmi_n |-> o_vec_valid;
   endproperty
   a_nmi_release: assert property (p_nmi_release)
      else $error("request released without vector");
   property p_rdy_cause;
      $fell(o_rdy) |-> $past(i_cpu.vec_fetch);
   endproperty
   a_rdy_cause: assert property (p_rdy_cause)
      else $error("stall without vector fetch");
endmodule

bind nmi_irq_ctrl nmi_irq_ctrl_properties i_props (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_reg(i_reg),
   .o_reg_rdata(o_reg_rdata), .i_cpu(i_cpu), .o_nmi_n(o_nmi_n), .o_rdy(o_rdy), .o_vec_valid(o_vec_valid),
   .o_vec_addr(o_vec_addr));

// ===== cpu_core_model.sv
`timescale 1ns/1ps
module cpu_core_model (
   input  wire logic            i_ref_clk,
   input  wire logic            i_rst_n,
   input  wire logic            i_nmi_n,
   input  wire logic            i_rdy,
   input  wire logic            i_vec_valid,
   input  wire logic            i_slow,
   output nmi_irq_pkg::cpu_bus_t o_cpu,
   output logic                 o_instr_done
);
   logic [15:0] tick_q;
   logic [1:0]  seen_q;
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_n) begin
         tick_q       <= 16'h0000;
         seen_q       <= 2'h0;
         o_cpu        <= '0;
         o_instr_done <= 1'b0;
      end else begin
         tick_q       <= tick_q + 16'h0001;
         // a stalled cpu finishes nothing
         o_instr_done <= (tick_q[1:0] == 2'h3) && i_rdy && !o_cpu.vec_fetch;
         if (o_cpu.vec_fetch) begin
            if (i_vec_valid) o_cpu.vec_fetch <= 1'b0;
         end else if (!i_nmi_n && o_instr_done) begin
            // slow: the next instruction is finished too
            if (seen_q >= {1'b0, i_slow}) begin
               seen_q <= 2'h0;
               o_cpu  <= {i_slow ? nmi_irq_pkg::VEC_FETCH_NATIVE : nmi_irq_pkg::VEC_FETCH_EMU, 1'b1};
            end else seen_q <= seen_q + 2'h1;
         end else o_cpu.addr <= {8'h01, tick_q};
      end
   end
endmodule

// ===== nmi_irq_ctrl_tb.sv
`timescale 1ns/1ps
module nmi_irq_ctrl_tb;
   logic                  i_ref_clk = 1'b0;
   logic                  i_rst_n = 1'b0;
   nmi_irq_pkg::reg_req_t reg_q = '0;
   nmi_irq_pkg::cpu_bus_t cpu;
   logic                  instr_done, nmi_n, rdy, vec_valid, rd_q = 1'b0, slow = 1'b0, clk_en = 1'b1;
   logic [7:0]            opt0 = 8'h01;
   logic [31:0]           periph = 32'h0000_0000;
   logic [7:0]            rdata;
   logic [23:0]           vec_addr;
   logic [15:0]           src = 16'h0000;
   logic [3:0]            pin = 4'h0;
   logic [7:0]            exp_rd[$];
   logic [23:0]           exp_vec[$];
   int                    errors = 0, n_compared = 0, cycles = 0;

   always #25 i_ref_clk = ~i_ref_clk;

   nmi_irq_ctrl i_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_reg(reg_q),
      .o_reg_rdata(rdata), .i_cpu(cpu), .i_instr_done(instr_done), .o_nmi_n(nmi_n), .o_rdy(rdy),
      .o_vec_valid(vec_valid), .o_vec_addr(vec_addr), .i_direct_src(src), .i_pin_irq(pin),
      .i_periph_src(periph), .i_opt_byte0(opt0), .i_opt_byte1(8'h00), .i_opt_byte2(2'h0));
   cpu_core_model i_cpu_model (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_nmi_n(nmi_n), .i_rdy(rdy),
      .i_vec_valid(vec_valid), .i_slow(slow), .o_cpu(cpu), .o_instr_done(instr_done));
   ////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [23:0] vec(input int k);
      return nmi_irq_pkg::VEC_BASE - 24'(k) * nmi_irq_pkg::VEC_STEP;
   endfunction
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_q <= {a, d, 2'b10};
      @(posedge i_ref_clk);
      reg_q <= '0;
      @(posedge i_ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_rd.push_back(e);
      reg_q <= {a, 8'h00, 2'b01};
      @(posedge i_ref_clk);
      reg_q <= '0;
      @(posedge i_ref_clk);
   endtask
   task automatic pulse(input logic [15:0] m);
      src <= m;
      repeat (2) @(posedge i_ref_clk);
      src <= 16'h0000;
      @(posedge i_ref_clk);
   endtask
   task automatic ppulse(input logic [31:0] m);
      periph <= m;
      repeat (2) @(posedge i_ref_clk);
      periph <= 32'h0000_0000;
      @(posedge i_ref_clk);
   endtask
   task automatic pin_pulse(input logic [3:0] m);
      pin <= m;
      repeat (2) @(posedge i_ref_clk);
      pin <= 4'h0;
      repeat (2) @(posedge i_ref_clk);
   endtask
   task automatic quiet(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge i_ref_clk);
         check(24'(nmi_n), 24'h1);
      end
   endtask
   task automatic wait_vec();
      for (int i = 0; i < 200 && exp_vec.size() > 0; i++) @(posedge i_ref_clk);
      check(24'(exp_vec.size()), 24'h0);
      exp_vec.delete();
   endtask
   ////////////////////////////////////////////////////////////
   // read data and vectors are judged here, against the oldest note; quiet and wait_vec check too
   always @(posedge i_ref_clk) begin
      rd_q   <= reg_q.rd;
      cycles <= cycles + 1;
      if (rd_q) check(24'(rdata), 24'(exp_rd.pop_front()));
      if (vec_valid === 1'b1) check(vec_addr, exp_vec.pop_front());
      if (cycles == 6000) begin
         errors++;
         complete_run();
      end
   end

   initial begin
      logic [7:0] v;
      void'($urandom(46));
      repeat (6) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      @(posedge i_ref_clk);
      rd(nmi_irq_pkg::OFS_CONTROL, 8'h0c);
      rd(nmi_irq_pkg::OFS_RETURN, 8'hff);
      rd(nmi_irq_pkg::OFS_PENDING_HIGH, 8'hff);
      rd(8'h20, 8'h00);
      // a request while frozen is never seen
      clk_en <= 1'b0;
      pulse(16'h0004);
      clk_en <= 1'b1;
      rd(nmi_irq_pkg::OFS_RETURN, 8'hff);
      for (int k = 0; k < 8; k++) begin
         v = 8'($urandom);
         rd(nmi_irq_pkg::OFS_PRIO_BASE + 8'(k), 8'h00);
         wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'(k), v);
         rd(nmi_irq_pkg::OFS_PRIO_BASE + 8'(k), v);
      end
      wr(nmi_irq_pkg::OFS_CONTROL, 8'h0e);
      for (int k = 0; k < 8; k++) rd(nmi_irq_pkg::OFS_PRIO_BASE + 8'(k), 8'h00);
      rd(nmi_irq_pkg::OFS_CONTROL, 8'h0c);
      pulse(16'h0004);
      quiet(10);
      rd(nmi_irq_pkg::OFS_RETURN, 8'hfb);
      pulse(16'h1000);
      rd(nmi_irq_pkg::OFS_PENDING_HIGH, 8'hef);
      wr(nmi_irq_pkg::OFS_CONTROL, 8'h1e);
      rd(nmi_irq_pkg::OFS_RETURN, 8'hff);
      rd(nmi_irq_pkg::OFS_PENDING_HIGH, 8'hff);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h04, 8'h55);
      exp_vec.push_back(vec(9));
      pulse(16'h0300);
      wait_vec();
      quiet(12);
      rd(nmi_irq_pkg::OFS_PENDING_HIGH, 8'hfe);
      exp_vec.push_back(vec(8));
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wait_vec();
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h05, 8'h40);
      wr(nmi_irq_pkg::OFS_CONTROL, 8'h1b);
      rd(nmi_irq_pkg::OFS_CONTROL, 8'h08);
      pulse(16'h0800);
      quiet(12);
      slow <= 1'b1;
      exp_vec.push_back(vec(11));
      wr(nmi_irq_pkg::OFS_ENABLE_STB, 8'($urandom));
      quiet(1);
      wait_vec();
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h06, 8'h02);
      wr(nmi_irq_pkg::OFS_CONTROL, 8'h15);
      exp_vec.push_back(vec(12));
      pulse(16'h1000);
      wait_vec();
      rd(nmi_irq_pkg::OFS_CONTROL, 8'h00);
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wr(nmi_irq_pkg::OFS_CONTROL, 8'h1f);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h01, 8'h70);
      wr(nmi_irq_pkg::OFS_PORT_MODE, 8'h01);
      pin <= 4'h1;
      quiet(10);
      exp_vec.push_back(vec(3));
      pin <= 4'h0;
      wait_vec();
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wr(nmi_irq_pkg::OFS_PORT_PRESC, 8'h01);
      wr(nmi_irq_pkg::OFS_PORT_MODE, 8'h00);
      pin_pulse(4'h1);
      quiet(10);
      exp_vec.push_back(vec(3));
      pin_pulse(4'h1);
      wait_vec();
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h02, 8'h30);
      wr(nmi_irq_pkg::OFS_PRIO_BASE + 8'h03, 8'h60);
      ppulse(32'h0000_0001);
      quiet(10);
      rd(nmi_irq_pkg::OFS_RETURN, 8'hff);
      exp_vec.push_back(vec(5));
      ppulse(32'h0000_0002);
      wait_vec();
      wr(nmi_irq_pkg::OFS_RETURN, 8'h00);
      exp_vec.push_back(vec(7));
      pin_pulse(4'h8);
      wait_vec();
      complete_run();
   end
endmodule
